// file: design/iitf_defines.svh
// Purpose: command codes, reset values and field positions of the input/temperature limit bank
// Assumes: PMBus command engine hands over decoded command codes
// Notes:   definitions only
`ifndef IITF_DEFINES_SVH
`define IITF_DEFINES_SVH

// command codes
`define CMD_CLEAR_FAULTS       8'h03
`define CMD_STORE_DEFAULTS     8'h11
`define CMD_TEMP_WARN_LIM      8'h51
`define CMD_VIN_OV_LIMIT       8'h55
`define CMD_IIN_OC_FAULT_LIM   8'h5B
`define CMD_IIN_OC_REACTION    8'h5C
`define CMD_IIN_OC_WARN_LIM    8'h5D
`define CMD_FAULT_SUMMARY      8'h78
`define CMD_STATUS_WORD        8'h79
`define CMD_STATUS_INPUT       8'h7C
`define CMD_STATUS_TEMP        8'h7D

// reset and fixed values
`define RST_VIN_OV_NVM         16'h0011
`define RST_VIN_OV_STRAP       16'h000E
`define RST_IIN_OC_FAULT       16'h00FF
`define RST_IIN_OC_WARN        16'h0019
`define RST_OT_WARN            16'h005F
`define VAL_IIN_OC_REACTION    8'hC0
`define STORE_OV_BASE          16'h000E

// linear format fields
`define LIN_EXP_MSB            15
`define LIN_EXP_LSB            11
`define LIN_MANT_MSB           10
`define FIX_W                  44
`define FIX_BIAS               6'sh10

// fault summary byte bits
`define SB_OFF                 6
`define SB_VOUT_OV             5
`define SB_IOUT_OC             4
`define SB_VIN_UV              3
`define SB_TEMP                2
`define SB_CML                 1
`define SB_OTHER               0
// status word, input and temperature bits
`define SW_INPUT               13
`define SI_VIN_OV              7
`define SI_IIN_OC_FAULT        2
`define SI_IIN_OC_WARN         1
`define STT_OT_WARN            6

`endif

// file: design/iitf_pkg.sv
// Purpose: types of the input/temperature limit bank
// Assumes: iitf_defines.svh holds all numbers but the one-hot state codes below
// Notes:   types only
package iitf_pkg;

  typedef enum logic [3:0] {
    ST_SYNC0 = 4'b0001,
    ST_SYNC1 = 4'b0010,
    ST_LOAD  = 4'b0100,
    ST_RUN   = 4'b1000
  } iitf_state_t;

  typedef struct packed {
    logic [7:0]  code;
    logic        wr;
    logic        rd;
    logic [15:0] data;
  } iitf_cmd_t;

  typedef struct packed {
    logic        valid;
    logic        unmapped;
    logic [15:0] data;
  } iitf_rsp_t;

  typedef struct packed {
    logic [15:0] vin;
    logic [15:0] iin;
    logic [15:0] temp;
  } iitf_telem_t;

  typedef struct packed {
    logic vout_ov;
    logic iout_oc;
    logic vin_uv;
    logic cml;
  } iitf_ext_t;

  typedef struct packed {
    logic vin_ov;
    logic iin_oc_fault;
    logic iin_oc_warn;
    logic temp_warn;
    logic vout_ov;
    logic iout_oc;
    logic vin_uv;
    logic cml;
    logic other;
    logic input_any;
  } iitf_flags_t;

  typedef struct packed {
    iitf_state_t st;
    logic [1:0]  strap_sync;
    logic [15:0] ot_warn_lim;
    logic [15:0] vin_ov_lim;
    logic [15:0] iin_oc_lim;
    logic [15:0] iin_warn_lim;
    iitf_flags_t f;
    logic        alert;
    logic        reg_fault;
    iitf_rsp_t   rsp;
  } iitf_regs_t;

endpackage

// file: design/iitf_top.sv
// Purpose: input voltage/current and temperature limit registers with latched status
// Assumes: command engine and telemetry run on ref_clk; strap pin is asynchronous
// Notes:   telemetry arrives in 16-bit linear format like the limits
`timescale 1ns/1ps
`default_nettype none
`include "iitf_defines.svh"

module iitf_top
  import iitf_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // configuration strap, high when setup comes from nonvolatile memory
  input  wire logic        cfg_from_nvm,
  // command port from the bus engine
  input  wire iitf_cmd_t   cmd,
  output var  iitf_rsp_t   rsp,
  // telemetry and outside status
  input  wire iitf_telem_t telem,
  input  wire iitf_ext_t   ext_evt,
  input  wire logic        regulator_on,
  // alerts
  output logic             host_alert_out_n,
  output logic             regulator_fault_out,
  output logic             shutdown_out
);

  localparam iitf_regs_t RST = '{
    st:           ST_SYNC0,
    strap_sync:   2'h0,
    ot_warn_lim:  `RST_OT_WARN,
    vin_ov_lim:   `RST_VIN_OV_NVM,
    iin_oc_lim:   `RST_IIN_OC_FAULT,
    iin_warn_lim: `RST_IIN_OC_WARN,
    f:            '0,
    alert:        1'b0,
    reg_fault:    1'b0,
    rsp:          '0
  };

  iitf_regs_t q;
  iitf_regs_t d;

  // mantissa times two to the exponent, with 16 fractional bits so any exponent fits
  function automatic logic signed [`FIX_W-1:0] lin_to_fix(input logic [15:0] v);
    logic signed [5:0]        e;
    logic [5:0]               sh;
    logic signed [`FIX_W-1:0] m;
    e  = 6'($signed(v[`LIN_EXP_MSB:`LIN_EXP_LSB]));
    sh = 6'(e + `FIX_BIAS);
    m  = `FIX_W'($signed(v[`LIN_MANT_MSB:0]));
    return m <<< sh;
  endfunction

  // measured value at or above a limit
  function automatic logic reached(input logic [15:0] meas, input logic [15:0] lim);
    return lin_to_fix(meas) >= lin_to_fix(lim);
  endfunction

  // set wins over clear so an event in the clearing cycle is kept
  function automatic logic latch(input logic old, input logic clr, input logic set);
    return (old & ~clr) | set;
  endfunction

  logic        run;
  logic        clr;
  logic        hit_vin_ov;
  logic        hit_iin_oc;
  logic        hit_iin_warn;
  logic        hit_temp;
  logic        input_evt;
  logic [7:0]  sbyte;
  logic [15:0] sword;
  logic [7:0]  sinput;
  logic [7:0]  stemp;

  assign run = (q.st == ST_RUN);
  assign clr = run & cmd.wr & (cmd.code == `CMD_CLEAR_FAULTS);

  assign hit_vin_ov   = run & reached(telem.vin, q.vin_ov_lim);
  assign hit_iin_oc   = run & reached(telem.iin, q.iin_oc_lim);
  assign hit_iin_warn = run & reached(telem.iin, q.iin_warn_lim);
  assign hit_temp     = run & reached(telem.temp, q.ot_warn_lim);
  assign input_evt    = hit_vin_ov | hit_iin_oc | hit_iin_warn;

  // status views, built from the same flag storage; the OFF bit also takes ~regulator_on
  always_comb begin
    sbyte               = 8'h00;
    sbyte[`SB_OFF]      = ~regulator_on | q.f.iin_oc_fault;
    sbyte[`SB_VOUT_OV]  = q.f.vout_ov;
    sbyte[`SB_IOUT_OC]  = q.f.iout_oc;
    sbyte[`SB_VIN_UV]   = q.f.vin_uv;
    sbyte[`SB_TEMP]     = q.f.temp_warn;
    sbyte[`SB_CML]      = q.f.cml;
    sbyte[`SB_OTHER]    = q.f.other;
    sword               = 16'h0000;
    sword[7:0]          = sbyte;
    sword[`SW_INPUT]    = q.f.input_any;
    sinput              = 8'h00;
    sinput[`SI_VIN_OV]       = q.f.vin_ov;
    sinput[`SI_IIN_OC_FAULT] = q.f.iin_oc_fault;
    sinput[`SI_IIN_OC_WARN]  = q.f.iin_oc_warn;
    stemp               = 8'h00;
    stemp[`STT_OT_WARN] = q.f.temp_warn;
  end

  always_comb begin
    d            = q;
    d.rsp.valid  = 1'b0;
    d.strap_sync = {q.strap_sync[0], cfg_from_nvm};
    unique case (q.st)
      ST_SYNC0: begin
        d.st = ST_SYNC1;
      end
      ST_SYNC1: begin
        d.st = ST_LOAD;
      end
      ST_LOAD: begin
        // strap is stable in the second sync stage by now
        d.vin_ov_lim = q.strap_sync[1] ? `RST_VIN_OV_NVM : `RST_VIN_OV_STRAP;
        d.st         = ST_RUN;
      end
      ST_RUN: begin
        if (cmd.wr) begin
          unique case (cmd.code)
            `CMD_TEMP_WARN_LIM:      d.ot_warn_lim  = cmd.data;
            `CMD_VIN_OV_LIMIT:       d.vin_ov_lim   = cmd.data;
            `CMD_IIN_OC_FAULT_LIM:   d.iin_oc_lim   = cmd.data;
            `CMD_IIN_OC_WARN_LIM:    d.iin_warn_lim = cmd.data;
            `CMD_STORE_DEFAULTS: begin
              d.vin_ov_lim = `STORE_OV_BASE + {14'h0000, q.vin_ov_lim[1:0]};
            end
            default: begin
            end
          endcase
        end
        d.f.vin_ov       = latch(q.f.vin_ov, clr, hit_vin_ov);
        d.f.iin_oc_fault = latch(q.f.iin_oc_fault, clr, hit_iin_oc);
        d.f.iin_oc_warn  = latch(q.f.iin_oc_warn, clr, hit_iin_warn);
        d.f.temp_warn    = latch(q.f.temp_warn, clr, hit_temp);
        d.f.other        = latch(q.f.other, clr, input_evt);
        d.f.input_any    = latch(q.f.input_any, clr, input_evt);
        d.f.vout_ov      = latch(q.f.vout_ov, clr, ext_evt.vout_ov);
        d.f.iout_oc      = latch(q.f.iout_oc, clr, ext_evt.iout_oc);
        d.f.vin_uv       = latch(q.f.vin_uv, clr, ext_evt.vin_uv);
        d.f.cml          = latch(q.f.cml, clr, ext_evt.cml);
      end
      default: begin
        d.st = ST_SYNC0;
      end
    endcase

    // outputs follow the next flags so they move on the same edge as the status
    d.alert     = |d.f;
    d.reg_fault = d.f.iin_oc_fault;

    if (cmd.rd) begin
      d.rsp.valid    = 1'b1;
      d.rsp.unmapped = 1'b0;
      unique case (cmd.code)
        `CMD_TEMP_WARN_LIM:      d.rsp.data = q.ot_warn_lim;
        `CMD_VIN_OV_LIMIT:       d.rsp.data = q.vin_ov_lim;
        `CMD_IIN_OC_FAULT_LIM:   d.rsp.data = q.iin_oc_lim;
        `CMD_IIN_OC_WARN_LIM:    d.rsp.data = q.iin_warn_lim;
        `CMD_IIN_OC_REACTION:    d.rsp.data = {8'h00, `VAL_IIN_OC_REACTION};
        `CMD_FAULT_SUMMARY:      d.rsp.data = {8'h00, sbyte};
        `CMD_STATUS_WORD:        d.rsp.data = sword;
        `CMD_STATUS_INPUT:       d.rsp.data = {8'h00, sinput};
        `CMD_STATUS_TEMP:        d.rsp.data = {8'h00, stemp};
        default: begin
          d.rsp.data     = 16'h0000;
          d.rsp.unmapped = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end

  assign rsp                 = q.rsp;
  assign host_alert_out_n    = ~q.alert;
  assign regulator_fault_out = q.reg_fault;
  // no restart: the stage stays off until the host clears the fault
  assign shutdown_out        = q.f.iin_oc_fault;

endmodule

`default_nettype wire

// file: tb/iitf_host_model.sv
// Purpose: host side of the command port
// Assumes: requests launch at the falling edge
// Notes:   no ready: every strobe is taken, reads answer one cycle later
`timescale 1ns/1ps
`default_nettype none
module iitf_host_model
  import iitf_pkg::*;
(
  // command port
  input  wire logic      ref_clk,
  output var  iitf_cmd_t cmd,
  input  wire iitf_rsp_t rsp
);
  initial cmd = '0;
  task automatic put(input logic [7:0] code, input logic [15:0] data);
    @(negedge ref_clk);
    cmd = '{code, 1'b1, 1'b0, data};
    @(negedge ref_clk);
    cmd.wr = 1'b0;
    // stale data is inverted so nothing leans on it
    cmd.data = ~data;
  endtask
  task automatic get(input logic [7:0] code, output logic [17:0] ans);
    @(negedge ref_clk);
    cmd.code = code;
    cmd.rd = 1'b1;
    @(negedge ref_clk);
    cmd.rd = 1'b0;
    ans = {rsp.valid, rsp.unmapped, rsp.data};
  endtask
endmodule
`default_nettype wire

// file: tb/iitf_top_properties.sv
// Purpose: port checks for the input and temperature limit bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   reads are answered one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module iitf_top_properties
  import iitf_pkg::*;
(
  // watched ports
  input wire logic      ref_clk,
  input wire logic      resetn,
  input wire iitf_cmd_t cmd,
  input wire iitf_rsp_t rsp,
  input wire logic      host_alert_out_n,
  input wire logic      regulator_fault_out,
  input wire logic      shutdown_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic clr;
  // a clear in the cycle of a read may drop flags that the read still shows
  assign clr = cmd.wr && cmd.code == 8'h03;
  chk_summary_top: assert property (cmd.rd && cmd.code == 8'h78 |=> rsp.valid && rsp.data[15:7] == 9'h000)
    else $error("summary upper bits set");
  chk_reaction_fixed: assert property (cmd.rd && cmd.code == 8'h5C |=> rsp.data == 16'h00C0)
    else $error("reaction code wrong");
  chk_fault_alert: assert property (regulator_fault_out |-> !host_alert_out_n)
    else $error("fault without alert");
  chk_fault_shutdown: assert property (regulator_fault_out == shutdown_out)
    else $error("shutdown off the latch");
  chk_alert_holds: assert property (!host_alert_out_n && !clr |=> !host_alert_out_n)
    else $error("alert dropped without clear");
  chk_fault_holds: assert property (regulator_fault_out && !clr |=> regulator_fault_out)
    else $error("latch-off released without clear");
  chk_summary_alert: assert property (cmd.rd && cmd.code == 8'h78 && !clr
    ##1 rsp.data[5:0] != 6'h00 |-> !host_alert_out_n)
    else $error("summary flag without alert");
  chk_write_readback: assert property ($past(resetn, 4) && cmd.wr && cmd.code == 8'h5D
    ##1 !cmd.wr ##1 cmd.rd && cmd.code == 8'h5D |=> rsp.data == $past(cmd.data, 3))
    else $error("warning limit lost");
  cov_fault: cover property (regulator_fault_out);
  cov_alert: cover property (!host_alert_out_n);
  cov_unmapped: cover property (rsp.valid && rsp.unmapped);
endmodule
bind iitf_top iitf_top_properties u_props (.ref_clk, .resetn, .cmd, .rsp, .host_alert_out_n,
  .regulator_fault_out, .shutdown_out);
`default_nettype wire

// file: tb/iitf_top_tb.sv
// Purpose: self-checking bench for the input and temperature limit bank
// Assumes: inputs change at the falling edge of ref_clk
// Notes:   one limit is probed with a negative exponent to test the decode
`timescale 1ns/1ps
`default_nettype none
module iitf_top_tb
  import iitf_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cfg_from_nvm = 1'b1;
  logic        regulator_on = 1'b1;
  iitf_telem_t telem = '0;
  iitf_ext_t   ext_evt = '0;
  iitf_cmd_t   cmd;
  iitf_rsp_t   rsp;
  wire [2:0]   pins;
  int          fails = 0;
  int          n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  iitf_host_model u_host (.ref_clk(ref_clk), .cmd(cmd), .rsp(rsp));
  iitf_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .cfg_from_nvm(cfg_from_nvm), .cmd(cmd), .rsp(rsp),
    .telem(telem), .ext_evt(ext_evt), .regulator_on(regulator_on), .host_alert_out_n(pins[2]),
    .regulator_fault_out(pins[1]), .shutdown_out(pins[0]));
  task automatic complete_run;
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_read(input logic [7:0] code, input logic [15:0] exp, input logic unm = 1'b0);
    logic [17:0] ans;
    u_host.get(code, ans);
    check_word(ans, {1'b1, unm, exp});
  endtask
  task automatic check_pins(input logic [2:0] exp);
    check_word({15'h0000, pins}, {15'h0000, exp});
  endtask
  task automatic clear_all;
    telem = '0;
    ext_evt = '0;
    u_host.put(8'h03, 16'h0000);
  endtask
  task automatic do_reset(input logic nvm);
    cfg_from_nvm = nvm;
    resetn = 1'b0;
    repeat (6) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic test_reset_values;
    check_read(8'h55, 16'h0011);
    check_read(8'h5B, 16'h00FF);
    check_read(8'h5C, 16'h00C0);
    check_read(8'h5D, 16'h0019);
    check_read(8'h51, 16'h005F);
    check_read(8'h78, 16'h0000);
    check_read(8'hEE, 16'h0000, 1'b1);
    check_pins(3'b100);
  endtask
  task automatic test_store_defaults;
    for (int j = 0; j < 4; j++) begin
      u_host.put(8'h55, {14'h2AF0, j[1:0]});
      u_host.put(8'h11, 16'h0000);
      check_read(8'h55, 16'h000E + 16'(j));
    end
  endtask
  task automatic test_input_ov;
    telem.vin = 16'hF821;
    check_read(8'h78, 16'h0000);
    telem.vin = 16'hF822;
    check_read(8'h78, 16'h0001);
    check_read(8'h79, 16'h2001);
    check_read(8'h7C, 16'h0080);
    check_pins(3'b000);
    telem.vin = 16'h0000;
    check_read(8'h78, 16'h0001);
    clear_all;
    check_read(8'h79, 16'h0000);
  endtask
  task automatic test_input_oc;
    telem.iin = 16'h00FF;
    check_read(8'h78, 16'h0041);
    check_read(8'h79, 16'h2041);
    check_read(8'h7C, 16'h0006);
    check_pins(3'b011);
    telem.iin = 16'h0000;
    check_read(8'h5C, 16'h00C0);
    check_pins(3'b011);
    clear_all;
    check_pins(3'b100);
  endtask
  task automatic test_input_warn;
    telem.iin = 16'h0018;
    check_read(8'h7C, 16'h0000);
    telem.iin = 16'h0019;
    check_read(8'h7C, 16'h0002);
    check_read(8'h78, 16'h0001);
    check_pins(3'b000);
    clear_all;
  endtask
  task automatic test_temp_and_events;
    telem.temp = 16'h005F;
    check_read(8'h7D, 16'h0040);
    check_read(8'h78, 16'h0004);
    clear_all;
    ext_evt = '{1'b1, 1'b0, 1'b0, 1'b1};
    check_read(8'h78, 16'h0022);
    check_pins(3'b000);
    clear_all;
    ext_evt = '{1'b0, 1'b1, 1'b1, 1'b0};
    check_read(8'h78, 16'h0018);
    check_read(8'h79, 16'h0018);
    check_pins(3'b000);
    clear_all;
    regulator_on = 1'b0;
    check_read(8'h78, 16'h0040);
    check_pins(3'b100);
    regulator_on = 1'b1;
  endtask
  task automatic test_limit_access;
    logic [7:0] code [4] = '{8'h51, 8'h55, 8'h5B, 8'h5D};
    // large positive limits keep every comparison quiet; mantissa bit 10 stays clear
    for (int i = 0; i < 4; i++) begin
      u_host.put(code[i], {12'h7BF, i[3:0]});
      check_read(code[i], {12'h7BF, i[3:0]});
    end
    u_host.put(8'h5C, 16'h0000);
    check_read(8'h5C, 16'h00C0);
  endtask
  initial begin
    do_reset(1'b1);
    test_reset_values;
    test_store_defaults;
    test_input_ov;
    test_input_oc;
    test_input_warn;
    test_temp_and_events;
    test_limit_access;
    do_reset(1'b0);
    check_read(8'h55, 16'h000E);
    complete_run;
  end
  initial begin
    // the sequence needs about 130 cycles
    #50us;
    fails++;
    complete_run;
  end
endmodule
`default_nettype wire
